//--- hw/ramb_defs.vh
// constants for the banked data ram address block
`ifndef RAMB_DEFS_VH
`define RAMB_DEFS_VH

// ****************
// memory layout
// ****************
`define RAMB_RAM_BYTES 512
`define RAMB_IDX_W 9
`define RAMB_BANK0_GEN_END 10'h07f
`define RAMB_BANK1_BASE 10'h100
`define RAMB_BANK1_END 10'h1ff
`define RAMB_BANK2_BASE 10'h200
`define RAMB_BANK2_END 10'h27f
`define RAMB_BANK1_IDX 9'h080
`define RAMB_BANK2_IDX 9'h180
`define RAMB_NODIRECT_A 10'h190
`define RAMB_NODIRECT_B 10'h191

// ****************
// system register addresses in bank 0
// ****************
`define RAMB_SYS_L 8'h80
`define RAMB_SYS_H 8'h81
`define RAMB_SYS_Z 8'h83
`define RAMB_SYS_Y 8'h84
`define RAMB_SYS_BANK 8'h87
`define RAMB_SYS_HL_WIN 8'h90
`define RAMB_SYS_YZ_WIN 8'h91

// ****************
// apb byte offsets
// ****************
`define RAMB_APB_L 8'h00
`define RAMB_APB_H 8'h04
`define RAMB_APB_Z 8'h08
`define RAMB_APB_Y 8'h0c
`define RAMB_APB_BANK 8'h10
`define RAMB_APB_HL_WIN 8'h14
`define RAMB_APB_YZ_WIN 8'h18
`define RAMB_APB_STATUS 8'h1c

// ****************
// reset values
// ****************
`define RAMB_PTR_RST 8'h00
`define RAMB_BANK_RST 2'h0

`endif

//--- hw/ramb_mem.v
// flip-flop storage for the 512 general purpose bytes
`timescale 1ns/1ps
`default_nettype none

module ramb_mem #(
  parameter DEPTH = 512,
  parameter IDX_W = 9
) (
  input wire clk,
  input wire wr_en,
  input wire [IDX_W-1:0] wr_idx,
  input wire [7:0] wr_data,
  input wire [IDX_W-1:0] rd_idx,
  output wire [7:0] rd_data
);

  // no reset: ram content is undefined at power up, as in the core
  reg [7:0] mem_reg [0:DEPTH-1];

  always @(posedge clk) begin
    if (wr_en) begin
      mem_reg[wr_idx] <= wr_data;
    end
  end

  assign rd_data = mem_reg[rd_idx];

endmodule // ramb_mem

`default_nettype wire

//--- hw/ramb_bank_ctl.v
// bank selector with one level of save and restore around interrupts
`include "ramb_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module ramb_bank_ctl (
  input wire clk,
  input wire rst_n,
  input wire wr_en,
  input wire [1:0] wr_bank,
  input wire int_entry,
  input wire int_return,
  output reg [1:0] bank_reg,
  output reg [1:0] saved_reg,
  output reg in_isr_reg
);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bank_reg <= `RAMB_BANK_RST;
      saved_reg <= `RAMB_BANK_RST;
      in_isr_reg <= 1'b0;
    end else begin
      if (int_return) begin
        // restore wins over a write in the same cycle
        bank_reg <= saved_reg; // R5
        in_isr_reg <= 1'b0;
      end else if (wr_en) begin
        bank_reg <= wr_bank; // R4
      end
      if (int_entry && !int_return) begin
        // save only; the active bank is left as it is
        saved_reg <= bank_reg; // R3
        in_isr_reg <= 1'b1;
      end
    end
  end

endmodule // ramb_bank_ctl

`default_nettype wire

//--- hw/ramb_top.v
// banked data ram address logic with pointer windows and apb access
//
// Overview of operation
// R1: 512 bytes: bank 0 000-0ff (upper half system), 1 100-1ff, 2 200-27f.
// R2: direct accesses use the bank chosen by the bank selector, 0, 1 or 2.
// R3: interrupt entry saves the selector and leaves the active bank unchanged.
// R4: software may rewrite the selector in a service routine; acts at once.
// R5: return from interrupt reloads the selector with the saved value.
// R6: bank-zero instruction variants always address bank 0.
// R7: 190h and 191h are unreachable directly, only through the two windows.
// R8: the first window accesses the location addressed by the h/l pair.
// R9: the second window accesses the location addressed by the y/z pair.
// R10: the selector holds only two bank bits; other bits read zero.
// R11: direct address is the bank number above the 8-bit operand.
`include "ramb_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module ramb_top (
  input wire ref_clk,
  input wire arst_n,
  input wire core_req,
  input wire core_wr,
  input wire core_bank_zero,
  input wire [7:0] core_addr,
  input wire [7:0] core_wdata,
  output reg [7:0] core_rdata_reg,
  output reg core_rvalid_reg,
  input wire int_entry,
  input wire return_from_interrupt,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata_reg,
  output reg pready_reg,
  output reg pslverr_reg,
  output wire [1:0] active_bank
);

  // ****************
  // reset release
  // ****************
  // logic leaves reset two edges after the pin, always on a clock edge
  reg rst_meta_reg;
  reg rst_n_reg;

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // ****************
  // functions
  // ****************
  // maps a 16-bit ram address to {ok, index}; system area and holes are off
  function [`RAMB_IDX_W:0] ram_index;
    input [15:0] a;
    reg [9:0] a10;
    reg [9:0] rel;
    begin
      a10 = a[9:0];
      rel = a10 - `RAMB_BANK1_BASE;
      ram_index = {1'b0, {`RAMB_IDX_W{1'b0}}};
      if (a[15:10] == 6'h00) begin
        if (a10 <= `RAMB_BANK0_GEN_END) begin
          ram_index = {1'b1, a10[8:0]}; // R1
        end else if (a10 >= `RAMB_BANK1_BASE && a10 <= `RAMB_BANK1_END) begin
          // bank 1 follows the 128 general bytes of bank 0 in storage
          ram_index = {1'b1, rel[8:0] + `RAMB_BANK1_IDX};
        end else if (a10 >= `RAMB_BANK2_BASE && a10 <= `RAMB_BANK2_END) begin
          ram_index = {1'b1, a10[8:0] + `RAMB_BANK2_IDX};
        end
      end
    end
  endfunction

  // maps an apb byte offset to the equivalent bank 0 system address
  function [8:0] apb_to_sys;
    input [7:0] off;
    begin
      case (off)
        `RAMB_APB_L: apb_to_sys = {1'b1, `RAMB_SYS_L};
        `RAMB_APB_H: apb_to_sys = {1'b1, `RAMB_SYS_H};
        `RAMB_APB_Z: apb_to_sys = {1'b1, `RAMB_SYS_Z};
        `RAMB_APB_Y: apb_to_sys = {1'b1, `RAMB_SYS_Y};
        `RAMB_APB_BANK: apb_to_sys = {1'b1, `RAMB_SYS_BANK};
        `RAMB_APB_HL_WIN: apb_to_sys = {1'b1, `RAMB_SYS_HL_WIN};
        `RAMB_APB_YZ_WIN: apb_to_sys = {1'b1, `RAMB_SYS_YZ_WIN};
        default: apb_to_sys = 9'h000;
      endcase
    end
  endfunction

  // true when a full address names one system register of bank 0
  function sys_sel;
    input [9:0] full;
    input [7:0] a;
    begin
      sys_sel = (full[9:7] == 3'b001) && (full[7:0] == a);
    end
  endfunction

  // ****************
  // state
  // ****************
  reg [7:0] l_reg;
  reg [7:0] h_reg;
  reg [7:0] z_reg;
  reg [7:0] y_reg;
  wire [1:0] bank_reg;
  wire [1:0] saved_reg;
  wire in_isr_reg;
  wire [7:0] mem_rd_data;
  // status packs the interrupt save state for software inspection
  wire [31:0] status_word = {27'h0000000, in_isr_reg, saved_reg, bank_reg};

  // ****************
  // access arbitration
  // ****************
  // the core is never stalled; apb waits for a cycle without a core access
  wire apb_phase = psel && penable && !pready_reg;
  wire apb_go = apb_phase && !core_req;
  wire [8:0] apb_map = apb_to_sys(paddr);
  wire apb_status = (paddr == `RAMB_APB_STATUS);

  reg acc_valid;
  reg acc_wr;
  reg [9:0] acc_full;
  reg [7:0] acc_wdata;

  always @* begin
    acc_valid = 1'b0;
    acc_wr = 1'b0;
    acc_full = 10'h000;
    acc_wdata = 8'h00;
    if (core_req) begin
      acc_valid = 1'b1;
      acc_wr = core_wr;
      acc_wdata = core_wdata;
      if (core_bank_zero) begin
        acc_full = {2'b00, core_addr}; // R6
      end else begin
        acc_full = {bank_reg, core_addr}; // R2 R11
      end
    end else if (apb_go && apb_map[8]) begin
      acc_valid = 1'b1;
      acc_wr = pwrite;
      acc_wdata = pwdata[7:0];
      acc_full = {2'b00, apb_map[7:0]};
    end
  end

  // ****************
  // address decode
  // ****************
  wire is_sys = (acc_full[9:7] == 3'b001);
  wire [7:0] sys_a = acc_full[7:0];
  wire hl_win = sys_sel(acc_full, `RAMB_SYS_HL_WIN);
  wire yz_win = sys_sel(acc_full, `RAMB_SYS_YZ_WIN);
  // 190h/191h lie in bank 1 space; only the windows may reach them
  wire no_direct = (acc_full == `RAMB_NODIRECT_A) ||
    (acc_full == `RAMB_NODIRECT_B);

  reg [15:0] mem_addr;
  always @* begin
    if (hl_win) begin
      mem_addr = {h_reg, l_reg}; // R8
    end else if (yz_win) begin
      mem_addr = {y_reg, z_reg}; // R9
    end else begin
      mem_addr = {6'h00, acc_full};
    end
  end

  wire [`RAMB_IDX_W:0] map = ram_index(mem_addr);
  wire direct_blocked = no_direct && !hl_win && !yz_win; // R7
  wire mem_hit = map[`RAMB_IDX_W] && !direct_blocked &&
    (hl_win || yz_win || !is_sys);
  wire mem_we = acc_valid && acc_wr && mem_hit;

  ramb_mem #(
    .DEPTH(`RAMB_RAM_BYTES),
    .IDX_W(`RAMB_IDX_W)
  ) u_mem (
    .clk(ref_clk),
    .wr_en(mem_we),
    .wr_idx(map[`RAMB_IDX_W-1:0]),
    .wr_data(acc_wdata),
    .rd_idx(map[`RAMB_IDX_W-1:0]),
    .rd_data(mem_rd_data)
  );

  wire bank_we = acc_valid && acc_wr && sys_sel(acc_full, `RAMB_SYS_BANK);

  ramb_bank_ctl u_bank (
    .clk(ref_clk),
    .rst_n(rst_n_reg),
    .wr_en(bank_we),
    .wr_bank(acc_wdata[1:0]), // R10
    .int_entry(int_entry),
    .int_return(return_from_interrupt),
    .bank_reg(bank_reg),
    .saved_reg(saved_reg),
    .in_isr_reg(in_isr_reg)
  );

  assign active_bank = bank_reg;

  // ****************
  // read mux
  // ****************
  // unused system addresses and holes read as zero
  reg [7:0] rd_val;
  always @* begin
    rd_val = 8'h00;
    if (mem_hit) begin
      rd_val = mem_rd_data;
    end else if (is_sys) begin
      case (sys_a)
        `RAMB_SYS_L: rd_val = l_reg;
        `RAMB_SYS_H: rd_val = h_reg;
        `RAMB_SYS_Z: rd_val = z_reg;
        `RAMB_SYS_Y: rd_val = y_reg;
        `RAMB_SYS_BANK: rd_val = {6'h00, bank_reg}; // R10
        default: rd_val = 8'h00;
      endcase
    end
  end

  // ****************
  // pointer registers
  // ****************
  always @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      l_reg <= `RAMB_PTR_RST;
      h_reg <= `RAMB_PTR_RST;
      z_reg <= `RAMB_PTR_RST;
      y_reg <= `RAMB_PTR_RST;
    end else if (acc_valid && acc_wr && is_sys) begin
      // window writes go to ram, never to the pointers
      case (sys_a)
        `RAMB_SYS_L: l_reg <= acc_wdata;
        `RAMB_SYS_H: h_reg <= acc_wdata;
        `RAMB_SYS_Z: z_reg <= acc_wdata;
        `RAMB_SYS_Y: y_reg <= acc_wdata;
        default: l_reg <= l_reg;
      endcase
    end
  end

  // ****************
  // core read answer
  // ****************
  always @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      core_rdata_reg <= 8'h00;
      core_rvalid_reg <= 1'b0;
    end else begin
      // rdata holds until the next read; rvalid marks the fresh value
      core_rvalid_reg <= core_req && !core_wr;
      if (core_req && !core_wr) begin
        core_rdata_reg <= rd_val;
      end
    end
  end

  // ****************
  // apb slave
  // ****************
  // the access is done in the granted cycle and answered one edge later,
  // so read data always comes from a flip-flop
  always @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else if (apb_go) begin
      pready_reg <= 1'b1;
      pslverr_reg <= !apb_map[8] && !(apb_status && !pwrite);
      // status is read only; a write to it is answered with an error
      if (apb_status) begin
        prdata_reg <= status_word;
      end else if (apb_map[8]) begin
        prdata_reg <= {24'h000000, rd_val};
      end else begin
        prdata_reg <= 32'h00000000;
      end
    end else begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

endmodule // ramb_top

`default_nettype wire

//--- dv/ramb_core_model.sv
// core datapath model driving the memory port
`timescale 1ns/1ps
`default_nettype none
module ramb_core_model (
  input wire logic ref_clk,
  output logic core_req,
  output logic core_wr,
  output logic core_bank_zero,
  output logic [7:0] core_addr,
  output logic [7:0] core_wdata,
  output logic int_entry,
  output logic return_from_interrupt,
  input wire logic [7:0] core_rdata_reg
);
  // ***
  // core side
  // ***
  initial begin
    core_req = 1'b0;
    core_wr = 1'b0;
    core_bank_zero = 1'b0;
    core_addr = 8'h00;
    core_wdata = 8'h00;
    int_entry = 1'b0;
    return_from_interrupt = 1'b0;
  end
  // idle address and data lines show the inverse so stale values never look valid
  task acc(input logic w, input logic z, input logic [7:0] a,
           input logic [7:0] d, output logic [7:0] q);
    @(posedge ref_clk);
    core_req <= 1'b1;
    core_wr <= w;
    core_bank_zero <= z;
    core_addr <= a;
    core_wdata <= d;
    @(posedge ref_clk);
    core_req <= 1'b0;
    core_addr <= ~a;
    core_wdata <= ~d;
    #1 q = core_rdata_reg;
  endtask
  task pulse(input logic r);
    @(posedge ref_clk);
    int_entry <= ~r;
    return_from_interrupt <= r;
    @(posedge ref_clk);
    int_entry <= 1'b0;
    return_from_interrupt <= 1'b0;
    #1;
  endtask
endmodule // ramb_core_model
`default_nettype wire

//--- dv/ramb_top_assertions.sv
// concurrent checks on the bank address block ports
`timescale 1ns/1ps
`default_nettype none
module ramb_chk (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic core_req,
  input wire logic core_wr,
  input wire logic core_bank_zero,
  input wire logic [7:0] core_addr,
  input wire logic [7:0] core_wdata,
  input wire logic [7:0] core_rdata_reg,
  input wire logic int_entry,
  input wire logic return_from_interrupt,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata_reg,
  input wire logic pready_reg,
  input wire logic pslverr_reg,
  input wire logic [1:0] active_bank
);
  // ***
  // checks
  // ***
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  logic [1:0] sav_reg;
  logic rd;
  assign rd = core_req && !core_wr && !core_bank_zero;
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) sav_reg <= 2'h0;
    else if (int_entry) sav_reg <= active_bank;
  end
  a_entry_keep: assert property (int_entry && !core_req && !psel
    |=> $stable(active_bank)) else $error("bank moved on entry");
  a_return_from_interrupt_load: assert property (return_from_interrupt
    |=> active_bank == sav_reg) else $error("bank not restored");
  a_bank_hold: assert property (!return_from_interrupt && !core_req
    && !(psel && penable) |=> $stable(active_bank))
    else $error("bank changed by itself");
  a_sel_write: assert property (core_req && core_wr
    && core_addr == 8'h87 && (core_bank_zero || active_bank == 2'h0)
    && !return_from_interrupt |=> active_bank == $past(core_wdata[1:0]))
    else $error("selector write lost");
  a_no_direct: assert property (rd && active_bank == 2'h1
    && core_addr[7:1] == 7'h48 |=> core_rdata_reg == 8'h00)
    else $error("direct read of window bytes");
  a_bank2_end: assert property (rd && active_bank == 2'h2
    && core_addr[7] |=> core_rdata_reg == 8'h00)
    else $error("read past bank 2 end");
  a_bank3_none: assert property (rd && active_bank == 2'h3
    |=> core_rdata_reg == 8'h00) else $error("bank 3 answered");
  a_sel_narrow: assert property (pready_reg && !pwrite
    && paddr == 8'h10 |-> prdata_reg[31:2] == 30'h0)
    else $error("selector too wide");
  c_entry: cover property (int_entry);
  c_return: cover property (return_from_interrupt);
  c_slverr: cover property (pslverr_reg);
endmodule // ramb_chk
bind ramb_top ramb_chk u_chk (.*);
`default_nettype wire

//--- dv/test_ramb_top.sv
// self-checking bench for the banked ram address block
`timescale 1ns/1ps
`default_nettype none
module test_ramb_top;
  // ***
  // bench
  // ***
  logic ref_clk;
  logic arst_n;
  logic core_req, core_wr, core_bank_zero, int_entry, return_from_interrupt;
  logic [7:0] core_addr, core_wdata, core_rdata_reg, paddr, q;
  logic core_rvalid_reg, psel, penable, pwrite, pready_reg, pslverr_reg, pe;
  logic [31:0] pwdata, prdata_reg, pq;
  logic [1:0] active_bank;
  int miscompares, checks, cyc;
  ramb_top DUT (.*);
  ramb_core_model core (.*);
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task cw(input logic z, input logic [7:0] a, input logic [7:0] d);
    core.acc(1'b1, z, a, d, q);
  endtask
  task cr(input logic z, input logic [7:0] a, input logic [7:0] e);
    core.acc(1'b0, z, a, 8'h00, q);
    chk({24'h0, q}, {24'h0, e});
    chk({31'h0, core_rvalid_reg}, 32'h1);
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // ends on pready_reg; if it never comes only the bench timeout ends this wait
    do begin
      @(posedge ref_clk);
    end while (pready_reg !== 1'b1);
    pq = prdata_reg;
    pe = pslverr_reg;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task give_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task t_banks;
    for (int b = 0; b < 3; b++) begin
      cw(1'b1, 8'h87, 8'(b));
      cw(1'b0, 8'h10, 8'h30 + 8'(b));
    end
    for (int b = 0; b < 3; b++) begin
      cw(1'b1, 8'h87, 8'(b));
      chk(32'(active_bank), b);
      cr(1'b0, 8'h10, 8'h30 + 8'(b));
    end
    cr(1'b1, 8'h10, 8'h30);
    cr(1'b0, 8'h90, 8'h00);
    $display("t_banks done");
  endtask
  task t_sel;
    cw(1'b1, 8'h87, 8'hff);
    cr(1'b1, 8'h87, 8'h03);
    cr(1'b0, 8'h10, 8'h00);
    apb(1'b0, 8'h10, 32'h0);
    chk(pq, 32'h3);
    chk(32'(pe), 32'h0);
    apb(1'b1, 8'h10, 32'hffff_fff9);
    chk(32'(active_bank), 32'h1);
    apb(1'b0, 8'h20, 32'h0);
    chk(32'(pe), 32'h1);
    $display("t_sel done");
  endtask
  task t_isr;
    core.pulse(1'b0);
    chk(32'(active_bank), 32'h1);
    cw(1'b1, 8'h87, 8'h02);
    cr(1'b0, 8'h10, 8'h32);
    apb(1'b0, 8'h1c, 32'h0);
    chk(pq, 32'h16);
    core.pulse(1'b1);
    chk(32'(active_bank), 32'h1);
    cr(1'b0, 8'h10, 8'h31);
    $display("t_isr done");
  endtask
  task t_win;
    cw(1'b1, 8'h80, 8'h90);
    cw(1'b1, 8'h81, 8'h01);
    cw(1'b1, 8'h83, 8'h91);
    cw(1'b1, 8'h84, 8'h01);
    cw(1'b1, 8'h90, 8'h5a);
    cw(1'b1, 8'h91, 8'ha5);
    cw(1'b0, 8'h90, 8'hee);
    cr(1'b0, 8'h91, 8'h00);
    cr(1'b1, 8'h90, 8'h5a);
    cr(1'b1, 8'h91, 8'ha5);
    cw(1'b1, 8'h80, 8'h10);
    cw(1'b1, 8'h81, 8'h02);
    apb(1'b0, 8'h14, 32'h0);
    chk(pq, 32'h32);
    $display("t_win done");
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (12) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_banks;
    t_sel;
    t_isr;
    t_win;
    give_verdict;
  end
  // ceiling well above the hundred or so cycles the tests need
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      miscompares++;
      give_verdict;
    end
  end
endmodule // test_ramb_top
`default_nettype wire
